// [verilog/ebm_regs.svh]
`ifndef EBM_REGS_SVH
`define EBM_REGS_SVH

// ----------------------------------------------------------------
// reset values of the pin drivers
// ----------------------------------------------------------------
`define EBM_RST_REQ_N 1'h1
`define EBM_RST_OCC_N 1'h1
`define EBM_RST_OCC_OE 1'h0
`define EBM_RST_LOCK_N 1'h1
`define EBM_RST_CAS_N 1'h1
`define EBM_RST_CAS_OE 1'h0

// ----------------------------------------------------------------
// timing counts, in core clock cycles
// ----------------------------------------------------------------
// cycles the occupied line is driven high before letting go
`define EBM_REL_CYCLES 2'h1

// ----------------------------------------------------------------
// forwarded bus clock, in link clock cycles
// ----------------------------------------------------------------
// link clock is four times the bus clock; phase 3 and 0 are high
`define EBM_BCLK_HI_A 2'h3
`define EBM_BCLK_HI_B 2'h0

`endif

// [verilog/ebm_pkg.sv]
package ebm_pkg;

  // arbitration state of the external bus end
  typedef enum logic [1:0] {
    EBM_SLAVE = 2'b00,
    EBM_WAIT_FREE = 2'b01,
    EBM_MASTER = 2'b10,
    EBM_RELEASE = 2'b11
  } ebm_arb_t;

  // instruction class of a read-modify-write access
  typedef enum logic [1:0] {
    EBM_INSTR_OTHER = 2'b00,
    EBM_INSTR_SET = 2'b01,
    EBM_INSTR_CLEAR = 2'b10,
    EBM_INSTR_CHG = 2'b11
  } ebm_instr_t;

  // read-modify-write request from the core
  typedef struct packed {
    logic start;
    logic ext;
    ebm_instr_t kind;
    logic write_end;
  } ebm_rmw_t;

  // core clock domain state
  typedef struct packed {
    ebm_arb_t arb;
    logic [1:0] rel_cnt;
    logic [1:0] grant_sync;
    logic [1:0] occ_sync;
    logic req_n;
    logic occ_n;
    logic occ_oe;
    logic lock;
    logic lock_n;
    logic cas_n;
    logic cas_oe;
    logic bclk_en;
    logic master; // registered copy of the owning state
  } ebm_core_t;

  // link clock domain state
  typedef struct packed {
    logic [1:0] en_sync;
    logic [1:0] phase;
    logic bclk;
    logic bclk_n;
    logic oe;
  } ebm_link_t;

endpackage

// [verilog/ebm_bclk_gen.sv]
`timescale 1ns/1ps
`include "ebm_regs.svh"

module ebm_bclk_gen (
  input wire logic i_link_clk,
  input wire logic i_arst_n,
  input wire logic i_enable,
  output logic o_bus_clk,
  output logic o_bus_clk_n,
  output logic o_bus_clk_oe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ebm_pkg::ebm_link_t st_q; // registered link state
  ebm_pkg::ebm_link_t st_d; // next link state

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // enable arrives from the core domain, so it passes two flops;
  // only en_sync[1] feeds the divider
  always_comb
  begin
    st_d = st_q;
    st_d.en_sync = {st_q.en_sync[0], i_enable};
    if (st_q.en_sync[1])
    begin
      // divide by four; high in phases 3 and 0 so the edge lands a
      // quarter period ahead of the core clock when the pll locks
      st_d.phase = st_q.phase + 2'h1;
      st_d.bclk = (st_d.phase == `EBM_BCLK_HI_A) ||
                  (st_d.phase == `EBM_BCLK_HI_B);
      st_d.bclk_n = ~st_d.bclk;
      st_d.oe = 1'h1;
    end
    else
    begin
      // parked low and floating while not master or not enabled
      st_d.phase = 2'h0;
      st_d.bclk = 1'h0;
      st_d.bclk_n = 1'h1;
      st_d.oe = 1'h0;
    end
  end

  // register, link clock domain only
  always_ff @(posedge i_link_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st_q <= '{en_sync: 2'h0, phase: 2'h0, bclk: 1'h0,
                bclk_n: 1'h1, oe: 1'h0};
    else
      st_q <= st_d;
  end

  assign o_bus_clk = st_q.bclk;
  assign o_bus_clk_n = st_q.bclk_n;
  assign o_bus_clk_oe = st_q.oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_bclk_inverse: assert property (@(posedge i_link_clk)
    disable iff (!i_arst_n) st_q.oe |-> (st_q.bclk_n == !st_q.bclk))
    else $error("bus clock complement is not the exact inverse");

  a_bclk_off: assert property (@(posedge i_link_clk)
    disable iff (!i_arst_n) !st_q.en_sync[1] |=> !st_q.oe)
    else $error("bus clock driven while not enabled");

  a_bclk_period: assert property (@(posedge i_link_clk)
    disable iff (!i_arst_n)
    $rose(st_q.bclk) && st_q.en_sync[1] ##1 st_q.en_sync[1]
    |-> st_q.bclk ##1 !st_q.bclk)
    else $error("bus clock high phase is not two link cycles");

endmodule

// [verilog/ebm_ctrl.sv]
// Function
// - drive occupied line synchronously to core clock
// - take bus only once occupied line released
// - may park, keeping occupied line after transfers
// - release by driving high, then stop driving
// - lock spans read, gap and write of rmw
// - lock stays off without locked rmw access
// - auto lock only for external bit instructions
// - lock-hold bit also asserts bus lock
// - drive column strobe while bus master
// - not master, enable clear: float column strobe
// - bus clock driven as master when enabled
// - bus clock leads core clock by quarter
// - complement clock is inverse, else floating
// - after grant, wait for occupied release
// - grant withdrawn: release at bus cycle end
// - reset deasserts request, returns to slave
`timescale 1ns/1ps
`include "ebm_regs.svh"

module ebm_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_link_clk,
  input wire logic i_bus_need,
  input wire logic i_cycle_active,
  input wire ebm_pkg::ebm_rmw_t i_rmw,
  input wire logic i_lock_hold_bit,
  input wire logic i_dram_master_enable_bit,
  input wire logic i_bus_clock_enable_bit,
  input wire logic i_col_strobe_n,
  input wire logic i_bus_grant_in_n,
  input wire logic i_bus_occupied_n,
  output logic o_bus_occupied_n,
  output logic o_bus_occupied_oe,
  output logic o_bus_request_out_n,
  output logic o_bus_lock_out_n,
  output logic o_col_strobe_n,
  output logic o_col_strobe_oe,
  output logic o_bus_clk,
  output logic o_bus_clk_n,
  output logic o_bus_clk_oe,
  output logic o_is_master
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true for the arbitration state that owns the bus
  function automatic logic ebm_is_master(input ebm_pkg::ebm_arb_t a);
    ebm_is_master = (a == ebm_pkg::EBM_MASTER);
  endfunction

  // true for a read-modify-write that must lock the bus
  function automatic logic ebm_locks(input ebm_pkg::ebm_rmw_t r);
    ebm_locks = r.start && r.ext &&
                (r.kind != ebm_pkg::EBM_INSTR_OTHER);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ebm_pkg::ebm_core_t st_q; // registered core state
  ebm_pkg::ebm_core_t st_d; // next core state
  logic granted; // synchronised grant, active high
  logic line_free; // synchronised occupied line reads released
  logic master_q; // current state owns the bus

  // only the second synchroniser stage is looked at
  assign granted = ~st_q.grant_sync[1];
  assign line_free = st_q.occ_sync[1];
  assign master_q = st_q.master;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;

    // pins from other masters and the arbiter: two flops first
    st_d.grant_sync = {st_q.grant_sync[0], i_bus_grant_in_n};
    st_d.occ_sync = {st_q.occ_sync[0], i_bus_occupied_n};

    // request follows the core's need, master or not
    st_d.req_n = ~i_bus_need;

    // arbitration
    case (st_q.arb)
      ebm_pkg::EBM_SLAVE:
      begin
        // wait for a grant before looking at the line
        if (granted)
          st_d.arb = ebm_pkg::EBM_WAIT_FREE;
      end
      ebm_pkg::EBM_WAIT_FREE:
      begin
        // grant alone is not enough; the line must be let go
        // by the previous owner first
        if (!granted)
          st_d.arb = ebm_pkg::EBM_SLAVE;
        else if (line_free)
          st_d.arb = ebm_pkg::EBM_MASTER;
      end
      ebm_pkg::EBM_MASTER:
      begin
        // parked while granted, even with the request dropped;
        // a withdrawn grant waits for the bus cycle to end, which
        // may split a multi-cycle instruction
        if (!granted && !i_cycle_active)
        begin
          st_d.arb = ebm_pkg::EBM_RELEASE;
          st_d.rel_cnt = `EBM_REL_CYCLES;
        end
      end
      ebm_pkg::EBM_RELEASE:
      begin
        // active pull-up pulse, then hand the line to the resistor
        if (st_q.rel_cnt == 2'h1)
        begin
          st_d.arb = ebm_pkg::EBM_SLAVE;
          st_d.rel_cnt = 2'h0;
        end
        else
          st_d.rel_cnt = st_q.rel_cnt - 2'h1;
      end
      default:
      begin
        st_d.arb = ebm_pkg::EBM_SLAVE;
      end
    endcase

    // occupied line, registered on the core clock
    case (st_d.arb)
      ebm_pkg::EBM_MASTER:
      begin
        // owned: drive low, kept low while parked
        st_d.occ_n = 1'h0;
        st_d.occ_oe = 1'h1;
      end
      ebm_pkg::EBM_RELEASE:
      begin
        // drive high so the line rises fast, not by the resistor
        st_d.occ_n = 1'h1;
        st_d.occ_oe = 1'h1;
      end
      default:
      begin
        // slave or waiting: input only
        st_d.occ_n = 1'h1;
        st_d.occ_oe = 1'h0;
      end
    endcase

    // lock: set by a locking rmw start, held across the read,
    // the gap and the write, cleared when the write ends; a start
    // in the same cycle as an end wins so no lock is lost
    if (ebm_locks(i_rmw))
      st_d.lock = 1'h1;
    else if (i_rmw.write_end)
      st_d.lock = 1'h0;
    st_d.lock_n = ~(st_d.lock | i_lock_hold_bit);

    // column strobe: follows the dram logic while master, parked
    // high when the enable bit keeps it driven, else floating
    if (master_q)
    begin
      st_d.cas_n = i_col_strobe_n;
      st_d.cas_oe = 1'h1;
    end
    else if (i_dram_master_enable_bit)
    begin
      st_d.cas_n = 1'h1;
      st_d.cas_oe = 1'h1;
    end
    else
    begin
      st_d.cas_n = 1'h1;
      st_d.cas_oe = 1'h0;
    end

    // bus clock enable, handed to the link domain as a level
    st_d.bclk_en = master_q && i_bus_clock_enable_bit;

    // mastership kept in its own flop so the pin comes straight
    // from a register rather than through a state decode
    st_d.master = ebm_is_master(st_d.arb);
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  // reset leaves request off, slave state, lock high, the rest
  // floating; synchronisers start at the idle pin levels
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st_q <= '{arb: ebm_pkg::EBM_SLAVE,
                rel_cnt: 2'h0,
                grant_sync: 2'h3,
                occ_sync: 2'h3,
                req_n: `EBM_RST_REQ_N,
                occ_n: `EBM_RST_OCC_N,
                occ_oe: `EBM_RST_OCC_OE,
                lock: 1'h0,
                lock_n: `EBM_RST_LOCK_N,
                cas_n: `EBM_RST_CAS_N,
                cas_oe: `EBM_RST_CAS_OE,
                bclk_en: 1'h0,
                master: 1'h0};
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign o_bus_occupied_n = st_q.occ_n;
  assign o_bus_occupied_oe = st_q.occ_oe;
  assign o_bus_request_out_n = st_q.req_n;
  assign o_bus_lock_out_n = st_q.lock_n;
  assign o_col_strobe_n = st_q.cas_n;
  assign o_col_strobe_oe = st_q.cas_oe;
  assign o_is_master = master_q;

  // ----------------------------------------------------------------
  // forwarded bus clock on the link clock
  // ----------------------------------------------------------------
  // the enable is a slow level, so a two-flop crossing is enough;
  // the clock starts a few link cycles after mastership is taken
  ebm_bclk_gen u_bclk (
    .i_link_clk(i_link_clk),
    .i_arst_n(i_arst_n),
    .i_enable(st_q.bclk_en),
    .o_bus_clk(o_bus_clk),
    .o_bus_clk_n(o_bus_clk_n),
    .o_bus_clk_oe(o_bus_clk_oe)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_occ_owned: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    master_q |-> st_q.occ_oe && !st_q.occ_n)
    else $error("occupied line not driven low while master");

  a_take_after_free: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    !master_q ##1 master_q
    |-> $past(line_free) && $past(granted))
    else $error("mastership taken before line was released");

  a_park_hold: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    master_q && granted |=> master_q)
    else $error("parked mastership dropped while still granted");

  a_release_pulse: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    master_q ##1 !master_q
    |-> st_q.occ_oe && st_q.occ_n ##1 !st_q.occ_oe)
    else $error("occupied line not released by one high pulse");

  a_lock_rmw: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    ebm_locks(i_rmw) |=> !st_q.lock_n)
    else $error("bus lock not raised by a locking bit instruction");

  a_lock_idle: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    !st_q.lock && !ebm_locks(i_rmw) && !i_lock_hold_bit
    |=> st_q.lock_n)
    else $error("bus lock asserted without a locked access");

  a_lock_other: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    i_rmw.start && i_rmw.kind == ebm_pkg::EBM_INSTR_OTHER
    && !st_q.lock && !i_lock_hold_bit |=> st_q.lock_n)
    else $error("bus lock set by a non bit instruction");

  a_lock_hold: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    i_lock_hold_bit |=> !st_q.lock_n)
    else $error("lock-hold bit did not assert bus lock");

  a_cas_master: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    master_q |=> st_q.cas_oe && st_q.cas_n == $past(i_col_strobe_n))
    else $error("column strobe not driven while master");

  a_cas_float: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    !master_q && !i_dram_master_enable_bit |=> !st_q.cas_oe)
    else $error("column strobe driven while slave and disabled");

  a_bclk_gate: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    !master_q |=> !st_q.bclk_en)
    else $error("bus clock enabled while not master");

  a_grant_loss: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    master_q && !granted && !i_cycle_active
    |=> st_q.arb == ebm_pkg::EBM_RELEASE)
    else $error("mastership kept after grant loss at cycle end");

  a_cycle_kept: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    master_q && i_cycle_active |=> master_q)
    else $error("mastership dropped in the middle of a bus cycle");

  a_request: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    !i_bus_need |=> st_q.req_n)
    else $error("bus request asserted without need");

  a_lock_gap: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    st_q.lock && !i_rmw.write_end |=> !st_q.lock_n)
    else $error("bus lock dropped before the write ended");

  a_lock_end: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    i_rmw.write_end && !ebm_locks(i_rmw) && !i_lock_hold_bit
    |=> st_q.lock_n)
    else $error("bus lock kept after the write ended");

  a_wait_busy: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    !master_q && !line_free |=> !master_q)
    else $error("mastership taken while the line was occupied");

  a_wait_float: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    st_q.arb == ebm_pkg::EBM_WAIT_FREE |-> !st_q.occ_oe)
    else $error("pending master drove the occupied line");

  a_cas_parked: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    !master_q && i_dram_master_enable_bit |=> st_q.cas_oe && st_q.cas_n)
    else $error("column strobe not parked high while enabled");

  a_bclk_on: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    master_q && i_bus_clock_enable_bit |=> st_q.bclk_en)
    else $error("bus clock not enabled while master");

  a_req_need: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    i_bus_need |=> !st_q.req_n)
    else $error("bus request not raised for a bus need");

endmodule

// [verification/ebm_far_end.sv]
`timescale 1ns/1ps

// arbiter and a second master on the far side of the bus
module ebm_far_end (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_grant_cmd,
  input wire logic i_other_cmd,
  input wire logic i_occ_n,
  input wire logic i_occ_oe,
  output logic o_bus_grant_in_n,
  output logic o_bus_occupied_n
);
  logic other_drv_q; // second master pulls the line low

  // ----------------------------------------------------------------
  // grant and second master, both on the core clock
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_bus_grant_in_n <= 1'h1;
      other_drv_q <= 1'h0;
    end
    else
    begin
      o_bus_grant_in_n <= ~i_grant_cmd;
      // takes the line only once it is seen free
      if (i_other_cmd && o_bus_occupied_n)
        other_drv_q <= 1'h1;
      else if (!i_other_cmd)
        other_drv_q <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // wire level with the pull-up
  // ----------------------------------------------------------------
  always_comb
  begin
    if (i_occ_oe)
      o_bus_occupied_n = i_occ_n;
    else if (other_drv_q)
      o_bus_occupied_n = 1'h0;
    else
      o_bus_occupied_n = 1'h1; // released line rises
  end
endmodule

// [verification/test_ext_bus_mastership_ctrl.sv]
`timescale 1ns/1ps

module test_ext_bus_mastership_ctrl;
  logic ref_clk = 1'h0;
  logic link_clk = 1'h0;
  logic arst_n = 1'h0;
  logic bus_need = 1'h0;
  logic cyc_act = 1'h0;
  ebm_pkg::ebm_rmw_t rmw = '0;
  logic lock_hold = 1'h0;
  logic dram_en = 1'h0;
  logic bclk_en = 1'h0;
  logic cas_in_n = 1'h1;
  logic grant_cmd = 1'h0; // far side grants us
  logic other_cmd = 1'h0; // far side master wants the bus
  logic grant_n, occ_wire_n, occ_n, occ_oe, req_n, lock_n;
  logic cas_n, cas_oe, bclk, bclk_n, bclk_oe, is_master;
  int error_cnt = 0;
  int checked = 0;

  // ----------------------------------------------------------------
  // clocks: link clock unrelated in phase to the core clock
  // ----------------------------------------------------------------
  always #20 ref_clk = ~ref_clk;
  always #16 link_clk = ~link_clk;

  ebm_ctrl ebm_ctrl_i (
    .i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_link_clk(link_clk),
    .i_bus_need(bus_need), .i_cycle_active(cyc_act), .i_rmw(rmw),
    .i_lock_hold_bit(lock_hold), .i_dram_master_enable_bit(dram_en),
    .i_bus_clock_enable_bit(bclk_en), .i_col_strobe_n(cas_in_n),
    .i_bus_grant_in_n(grant_n), .i_bus_occupied_n(occ_wire_n),
    .o_bus_occupied_n(occ_n), .o_bus_occupied_oe(occ_oe),
    .o_bus_request_out_n(req_n), .o_bus_lock_out_n(lock_n),
    .o_col_strobe_n(cas_n), .o_col_strobe_oe(cas_oe),
    .o_bus_clk(bclk), .o_bus_clk_n(bclk_n), .o_bus_clk_oe(bclk_oe),
    .o_is_master(is_master)
  );

  ebm_far_end ebm_far_end_i (
    .i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_grant_cmd(grant_cmd),
    .i_other_cmd(other_cmd), .i_occ_n(occ_n), .i_occ_oe(occ_oe),
    .o_bus_grant_in_n(grant_n), .o_bus_occupied_n(occ_wire_n)
  );

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic seen, input logic exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t ns: got %b expected %b", $time, seen, exp);
    end
  endtask

  // inputs change on the falling edge only
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // bounded wait for a mastership change
  task automatic wait_master(input logic v);
    int n;
    n = 0;
    while (is_master !== v && n < 12)
    begin
      cyc(1);
      n++;
    end
    if (is_master !== v)
    begin
      error_cnt++;
      $display("[FAIL] %0t ns: mastership wait timed out", $time);
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    bus_need = 1'h1; // request must stay off anyway
    cyc(5);
    chk(req_n, 1'h1);
    chk(is_master, 1'h0);
    chk(occ_oe, 1'h0);
    chk(lock_n, 1'h1);
    chk(cas_oe, 1'h0);
    chk(bclk_oe, 1'h0);
    arst_n = 1'h1;
    bus_need = 1'h0;
    cyc(2);
  endtask

  // one locked or unlocked rmw with a gap before the write end
  task automatic t_lock(input logic ext, input logic [1:0] kind);
    logic exp;
    exp = ext && (kind != 2'h0);
    rmw = '{1'h1, ext, ebm_pkg::ebm_instr_t'(kind), 1'h0};
    cyc(1);
    rmw.start = 1'h0;
    chk(lock_n, ~exp);
    cyc(3);
    chk(lock_n, ~exp);
    rmw.write_end = 1'h1;
    cyc(1);
    rmw.write_end = 1'h0;
    chk(lock_n, 1'h1);
    cyc(3);
    chk(lock_n, 1'h1);
  endtask

  task automatic t_hold();
    lock_hold = 1'h1;
    cyc(4);
    chk(lock_n, 1'h0);
    lock_hold = 1'h0;
    cyc(2);
    chk(lock_n, 1'h1);
  endtask

  // grant arrives while the other master still holds the line
  task automatic t_take();
    other_cmd = 1'h1;
    cyc(2);
    grant_cmd = 1'h1;
    bus_need = 1'h1;
    cyc(8);
    chk(is_master, 1'h0);
    chk(occ_oe, 1'h0);
    other_cmd = 1'h0;
    wait_master(1'h1);
    chk(occ_oe, 1'h1);
    chk(occ_n, 1'h0);
    chk(req_n, 1'h0);
  endtask

  // parking: need gone, grant kept
  task automatic t_park();
    bus_need = 1'h0;
    cyc(3);
    chk(req_n, 1'h1);
    chk(is_master, 1'h1);
    chk(occ_n, 1'h0);
  endtask

  task automatic t_cas();
    cas_in_n = 1'h0;
    cyc(2);
    chk(cas_oe, 1'h1);
    chk(cas_n, 1'h0);
    cas_in_n = 1'h1;
    cyc(2);
    chk(cas_n, 1'h1);
  endtask

  // forwarded clock: period of four link cycles, complement exact
  task automatic t_bclk();
    logic [7:0] s;
    bclk_en = 1'h1;
    cyc(4);
    chk(bclk_oe, 1'h1);
    for (int k = 0; k < 8; k++)
    begin
      @(negedge link_clk);
      s[k] = bclk;
      chk(bclk_n, ~bclk);
    end
    for (int k = 0; k < 4; k++)
    begin
      chk(s[k], s[k+4]);
      chk(s[k], ~s[k+2]);
    end
    bclk_en = 1'h0;
    cyc(4);
    chk(bclk_oe, 1'h0);
    bclk_en = 1'h1;
    cyc(4);
  endtask

  // grant withdrawn mid cycle; give up only when the cycle ends
  task automatic t_release();
    cyc_act = 1'h1;
    grant_cmd = 1'h0;
    cyc(6);
    chk(is_master, 1'h1);
    cyc_act = 1'h0;
    wait_master(1'h0);
    chk(occ_oe, 1'h1);
    chk(occ_n, 1'h1);
    cyc(1);
    chk(occ_oe, 1'h0);
    chk(cas_oe, 1'h0);
    dram_en = 1'h1;
    cyc(2);
    chk(cas_oe, 1'h1);
    chk(cas_n, 1'h1);
    dram_en = 1'h0;
    cyc(2);
    chk(cas_oe, 1'h0);
    cyc(4);
    chk(bclk_oe, 1'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    t_reset();
    for (int e = 0; e < 2; e++)
      for (int k = 0; k < 4; k++)
        t_lock(e == 1, 2'(k));
    t_hold();
    t_take();
    t_park();
    t_cas();
    t_bclk();
    t_release();
    end_sim();
  end
endmodule
